/* File: pkg/hpsp_pkg.sv */
`default_nettype none
package hpsp_pkg;
	// register offsets within a page
	localparam logic [7:0] OFF_PAGE_SEL   = 8'h00;
	localparam logic [7:0] OFF_ERR_RESP   = 8'h1e;
	localparam logic [7:0] OFF_HP_DRV     = 8'h1f;
	localparam logic [7:0] OFF_SPK_AMP    = 8'h20;
	localparam logic [7:0] PAGE_DRIVERS   = 8'h01;
	localparam logic [7:0] RST_PAGE_SEL   = 8'h00;
	localparam logic [7:0] RST_ERR_RESP   = 8'h00;
	localparam logic [7:0] RST_HP_DRV     = 8'h04;
	localparam logic [7:0] RST_SPK_AMP    = 8'h06;
	localparam logic [7:0] RST_RDATA      = 8'h00;
	// field positions
	localparam int HP_LEFT_PU_BIT  = 7;
	localparam int HP_RIGHT_PU_BIT = 6;
	localparam int HP_CM_LSB       = 3;
	localparam int HP_PROT_MODE_BIT = 1;
	localparam int HP_SHORT_BIT    = 0;
	localparam int ERR_HP_KEEP_BIT = 1;
	localparam int ERR_SPK_KEEP_BIT = 0;
	localparam int SPK_PU_BIT      = 7;
	localparam int SPK_SHORT_BIT   = 0;
	localparam int SYNC_STAGES     = 2;
endpackage : hpsp_pkg
`default_nettype wire

/* File: src/hpsp_sync.sv */
`default_nettype none
// two-flop level synchroniser; first stage read only by the second
module hpsp_sync (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic async_in,
	output logic      sync_out
);
	logic meta_reg;
	logic sync_reg;

	// stages kept separate so no logic taps the metastable flop
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end
	assign sync_out = sync_reg;
endmodule : hpsp_sync
`default_nettype wire

/* File: src/hpsp_regs.sv */
`default_nettype none
module hpsp_regs (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	output logic      [7:0] rdata,
	input  wire logic       hp_short_in,
	input  wire logic       spk_short_in,
	output logic            left_headphone_driver_pu,
	output logic            right_headphone_driver_pu,
	output logic      [1:0] hp_common_mode,
	output logic            hp_protect_powerdown,
	output logic            spk_driver_pu,
	output logic      [7:0] page_sel
);
	logic [7:0] page_reg;
	logic [7:0] err_reg;
	logic [7:0] hp_reg;
	logic [7:0] hp_next;
	logic [7:0] spk_reg;
	logic [7:0] spk_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic       hp_short_s;
	logic       spk_short_s;
	logic [1:0] short_raw;
	logic [1:0] short_sync;

	// pads come from analog comparators, so cross into mclk first;
	// slot 0 is the headphone comparator, slot 1 the speaker one
	assign short_raw = {spk_short_in, hp_short_in};
	for (genvar ch = 0; ch < 2; ch++) begin : g_short_sync
		hpsp_sync u_sync (
			.mclk     (mclk),
			.rst      (rst),
			.async_in (short_raw[ch]),
			.sync_out (short_sync[ch])
		);
	end
	assign hp_short_s  = short_sync[0];
	assign spk_short_s = short_sync[1];

	// address decode; page register visible on every page
	wire sel_page = (addr == hpsp_pkg::OFF_PAGE_SEL);
	wire on_p1    = (page_reg == hpsp_pkg::PAGE_DRIVERS);
	wire sel_err  = on_p1 && (addr == hpsp_pkg::OFF_ERR_RESP);
	wire sel_hp   = on_p1 && (addr == hpsp_pkg::OFF_HP_DRV);
	wire sel_spk  = on_p1 && (addr == hpsp_pkg::OFF_SPK_AMP);

	// load paths for the plain storage registers
	wire [7:0] page_next = (wr_en && sel_page) ? wdata : page_reg;
	wire [7:0] err_next  = (wr_en && sel_err) ? wdata : err_reg;

	// auto-clear conditions
	wire hp_keep   = err_reg[hpsp_pkg::ERR_HP_KEEP_BIT];
	wire hp_pdmode = hp_reg[hpsp_pkg::HP_PROT_MODE_BIT];
	wire hp_clear  = hp_short_s && !hp_keep && hp_pdmode;
	wire spk_clear = spk_short_s && !err_reg[hpsp_pkg::ERR_SPK_KEEP_BIT];

	// software write first, clear applied last so it wins
	always_comb begin
		hp_next = hp_reg;
		if (wr_en && sel_hp) begin
			hp_next = wdata;
		end
		hp_next[hpsp_pkg::HP_SHORT_BIT] = hp_short_s;
		if (hp_clear) begin
			hp_next[hpsp_pkg::HP_LEFT_PU_BIT]  = 1'b0;
			hp_next[hpsp_pkg::HP_RIGHT_PU_BIT] = 1'b0;
		end
	end

	// speaker path ignores the mode bit; only the keep bit gates the clear
	always_comb begin
		spk_next = spk_reg;
		if (wr_en && sel_spk) begin
			spk_next = wdata;
		end
		spk_next[hpsp_pkg::SPK_SHORT_BIT] = spk_short_s;
		if (spk_clear) begin
			spk_next[hpsp_pkg::SPK_PU_BIT] = 1'b0;
		end
	end

	// read mux; unmapped locations read zero
	always_comb begin
		rdata_next = rdata_reg;
		if (rd_en) begin
			rdata_next = sel_page ? page_reg :
				sel_err ? err_reg :
				sel_hp ? hp_reg :
				sel_spk ? spk_reg : 8'h00;
		end
	end

	// register state; reserved writes land nowhere
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			page_reg  <= hpsp_pkg::RST_PAGE_SEL;
			err_reg   <= hpsp_pkg::RST_ERR_RESP;
			hp_reg    <= hpsp_pkg::RST_HP_DRV;
			spk_reg   <= hpsp_pkg::RST_SPK_AMP;
			rdata_reg <= hpsp_pkg::RST_RDATA;
		end else begin
			page_reg  <= page_next;
			err_reg   <= err_next;
			hp_reg    <= hp_next;
			spk_reg   <= spk_next;
			rdata_reg <= rdata_next;
		end
	end

	assign rdata                     = rdata_reg;
	assign page_sel                  = page_reg;
	assign left_headphone_driver_pu  = hp_reg[hpsp_pkg::HP_LEFT_PU_BIT];
	assign right_headphone_driver_pu = hp_reg[hpsp_pkg::HP_RIGHT_PU_BIT];
	assign hp_common_mode            = hp_reg[hpsp_pkg::HP_CM_LSB +: 2];
	assign hp_protect_powerdown      = hp_reg[hpsp_pkg::HP_PROT_MODE_BIT];
	assign spk_driver_pu             = spk_reg[hpsp_pkg::SPK_PU_BIT];

	// assertions
	property p_page_reset;
		@(posedge mclk) $rose(rst) |-> ##1 (page_reg == 8'h00);
	endproperty
	a_page_reset: assert property (p_page_reset) else $error("page not reset");

	property p_page_write;
		@(posedge mclk) disable iff (rst) (wr_en && sel_page) |=> (page_reg == $past(wdata));
	endproperty
	a_page_write: assert property (p_page_write) else $error("page write lost");

	property p_hp_clear;
		@(posedge mclk) disable iff (rst) hp_clear |=> (!hp_reg[7] && !hp_reg[6]);
	endproperty
	a_hp_clear: assert property (p_hp_clear) else $error("hp power-up not cleared");

	property p_hp_keep;
		@(posedge mclk) disable iff (rst)
			(hp_keep && !(wr_en && sel_hp)) |=> (hp_reg[7:6] == $past(hp_reg[7:6]));
	endproperty
	a_hp_keep: assert property (p_hp_keep) else $error("hp power-up changed");

	property p_spk_clear;
		@(posedge mclk) disable iff (rst) spk_clear |=> !spk_reg[7];
	endproperty
	a_spk_clear: assert property (p_spk_clear) else $error("speaker not cleared");

	property p_hp_status;
		@(posedge mclk) disable iff (rst) ##1 hp_reg[0] == $past(hp_short_s);
	endproperty
	a_hp_status: assert property (p_hp_status) else $error("hp status wrong");

	property p_short_sync;
		@(posedge mclk) disable iff (rst) $rose(hp_short_s) |-> $past(hp_short_in, 2);
	endproperty
	a_short_sync: assert property (p_short_sync) else $error("sync depth wrong");

	property p_cm_write;
		@(posedge mclk) disable iff (rst)
			(wr_en && sel_hp) |=> (hp_common_mode == $past(wdata[4:3]));
	endproperty
	a_cm_write: assert property (p_cm_write) else $error("common mode lost");

	// reset, read path, load and protection checks
	property p_reset_values;
		@(posedge mclk) rst |->
			(hp_reg == hpsp_pkg::RST_HP_DRV) && (spk_reg == hpsp_pkg::RST_SPK_AMP);
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("reset value wrong");

	property p_err_write;
		@(posedge mclk) disable iff (rst) (wr_en && sel_err) |=> (err_reg == $past(wdata));
	endproperty
	a_err_write: assert property (p_err_write) else $error("error control write lost");

	property p_spk_keep;
		@(posedge mclk) disable iff (rst)
			(err_reg[0] && !(wr_en && sel_spk)) |=> $stable(spk_driver_pu);
	endproperty
	a_spk_keep: assert property (p_spk_keep) else $error("speaker power-up changed");

	property p_hp_limit;
		@(posedge mclk) disable iff (rst)
			(hp_short_s && !hp_pdmode && !(wr_en && sel_hp)) |=> $stable(hp_reg[7:6]);
	endproperty
	a_hp_limit: assert property (p_hp_limit) else $error("current-limit mode cleared drivers");

	property p_pu_write;
		@(posedge mclk) disable iff (rst)
			(wr_en && sel_hp && !hp_clear) |=> (hp_reg[7:6] == $past(wdata[7:6]));
	endproperty
	a_pu_write: assert property (p_pu_write) else $error("power-up write lost");

	property p_clear_wins;
		@(posedge mclk) disable iff (rst)
			(wr_en && sel_hp && hp_clear) |=> (hp_reg[7:6] == 2'b00);
	endproperty
	a_clear_wins: assert property (p_clear_wins) else $error("write beat auto clear");

	property p_rd_page;
		@(posedge mclk) disable iff (rst) (rd_en && sel_page) |=> (rdata == $past(page_reg));
	endproperty
	a_rd_page: assert property (p_rd_page) else $error("page readback wrong");

	property p_rd_unmapped;
		@(posedge mclk) disable iff (rst)
			(rd_en && !(sel_page || sel_err || sel_hp || sel_spk)) |=> (rdata == 8'h00);
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

	property p_rd_hp;
		@(posedge mclk) disable iff (rst) (rd_en && sel_hp) |=> (rdata == $past(hp_reg));
	endproperty
	a_rd_hp: assert property (p_rd_hp) else $error("headphone readback wrong");
endmodule : hpsp_regs
`default_nettype wire

/* File: bench/testbench.sv */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       mclk, rst, wr_en, rd_en, hp_s, spk_s;
	logic [7:0] addr, wdata, rdata, page_sel;
	logic       lpu, rpu, prot, spu;
	logic [1:0] cm;
	int         bad_count, check_count;
	hpsp_regs dut (.mclk(mclk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wdata(wdata), .rdata(rdata), .hp_short_in(hp_s), .spk_short_in(spk_s),
		.left_headphone_driver_pu(lpu), .right_headphone_driver_pu(rpu),
		.hp_common_mode(cm), .hp_protect_powerdown(prot), .spk_driver_pu(spu),
		.page_sel(page_sel));
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic test_done;
		if (bad_count == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : test_done
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// one-cycle strobes, launched 2 ns after the edge; an idle edge
	// follows so the next call never re-drives a strobe in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wr_en = 1'b1;
		addr = a;
		wdata = d;
		@(posedge mclk);
		#2 wr_en = 1'b0;
		@(posedge mclk);
		#2;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rd_en = 1'b1;
		addr = a;
		@(posedge mclk);
		#2 rd_en = 1'b0;
		chk("rdata", rdata, e);
		@(posedge mclk);
		#2;
	endtask : rd
	// short is async; allow sync stages plus update before looking
	task automatic short(input logic h, input logic s);
		hp_s = h;
		spk_s = s;
		repeat (4) @(posedge mclk);
		#2;
	endtask : short
	// generous bound, the tests need well under 400 cycles
	initial begin
		#100us;
		bad_count++;
		test_done();
	end
	initial begin
		{rst, wr_en, rd_en, hp_s, spk_s} = 5'b1_0000;
		addr = 8'h00;
		wdata = 8'h00;
		bad_count = 0;
		check_count = 0;
		repeat (16) @(posedge mclk);
		#2 rst = 1'b0;
		chk("pu", {5'h00, lpu, rpu, spu}, 8'h00);
		rd(8'h00, 8'h00);
		rd(8'h1f, 8'h00);
		wr(8'h00, 8'hff);
		rd(8'h00, 8'hff);
		chk("page_sel", page_sel, 8'hff);
		wr(8'h00, 8'h01);
		rd(8'h1e, 8'h00);
		rd(8'h1f, 8'h04);
		rd(8'h20, 8'h06);
		// every common-mode code, back to back with the readback
		for (int i = 0; i < 4; i++) begin
			wr(8'h1f, 8'hc4 | 8'(i << 3));
			rd(8'h1f, 8'hc4 | 8'(i << 3));
			chk("cm", {6'h00, cm}, 8'(i));
		end
		chk("pu", {6'h00, lpu, rpu}, 8'h03);
		// current-limit mode keeps drivers up; status is live
		short(1'b1, 1'b0);
		rd(8'h1f, 8'hdd);
		short(1'b0, 1'b0);
		wr(8'h1e, 8'h02);
		wr(8'h1f, 8'hc6);
		chk("prot", {7'h00, prot}, 8'h01);
		short(1'b1, 1'b0);
		chk("pu", {6'h00, lpu, rpu}, 8'h03);
		short(1'b0, 1'b0);
		wr(8'h1e, 8'h00);
		short(1'b1, 1'b0);
		rd(8'h1f, 8'h07);
		chk("pu", {6'h00, lpu, rpu}, 8'h00);
		// software write during a held short loses to auto clear
		wr(8'h1f, 8'hc6);
		@(posedge mclk);
		#2 chk("pu", {6'h00, lpu, rpu}, 8'h00);
		short(1'b0, 1'b0);
		rd(8'h1f, 8'h06);
		wr(8'h20, 8'h86);
		wr(8'h1e, 8'h01);
		short(1'b0, 1'b1);
		chk("spu", {7'h00, spu}, 8'h01);
		rd(8'h20, 8'h87);
		wr(8'h1e, 8'h00);
		@(posedge mclk);
		#2 chk("spu", {7'h00, spu}, 8'h00);
		short(1'b0, 1'b0);
		wr(8'h00, 8'h00);
		rd(8'h20, 8'h00);
		// second reset mid-run returns page and driver bits to defaults
		wr(8'h00, 8'h01);
		wr(8'h1f, 8'hc6);
		chk("pu", {6'h00, lpu, rpu}, 8'h03);
		rst = 1'b1;
		repeat (2) @(posedge mclk);
		#2 rst = 1'b0;
		chk("page_sel", page_sel, 8'h00);
		chk("pu", {5'h00, lpu, rpu, spu}, 8'h00);
		rd(8'h1f, 8'h00);
		test_done();
	end
endmodule : testbench
`default_nettype wire
